// [boot_prog_consts.svh]
// Constants for the boot self-programming sequencer
`ifndef BOOT_PROG_CONSTS_SVH
`define BOOT_PROG_CONSTS_SVH
`define PAGE_COUNT        128
`define PAGE_WORDS        64
`define FUSE_LOW_ADDR     16'h0000
`define FUSE_HIGH_ADDR    16'h0003
`define LOCK_ADDR         16'h0001
`define READ_WINDOW       3'h5
`define PAGE_MSB          13
`define PAGE_LSB          7
`define WORD_MSB          6
`define WORD_LSB          1
`define UNUSED_FILL       1'h1
`endif

// [boot_prog_pkg.sv]
// Types for the boot self-programming sequencer
package boot_prog_pkg;
    typedef enum logic [2:0] {
        CMD_NONE, CMD_FILL, CMD_ERASE, CMD_WRITE, CMD_LOCK
    } spm_cmd_t;
endpackage

// [boot_self_programming.sv]
// Boot self-programming sequencer between CPU and flash array
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`include "boot_prog_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module boot_self_programming
    import boot_prog_pkg::*;
(
    input  wire logic        sys_clk,       // 20 MHz clock
    input  wire logic        reset_n,       // Synchronous reset
    input  wire logic [12:0] fetchAddr,     // Word address of executing instruction
    input  wire logic        spmStrobe,     // Store-program instruction pulse
    input  wire logic [2:0]  spmCmd,        // Requested command (spm_cmd_t)
    input  wire logic [15:0] zPointer,      // Address pointer
    input  wire logic [15:0] spmData,       // Word for the temporary buffer
    input  wire logic        lockSetArm,    // Control write with lock-set and enable
    input  wire logic [3:0]  lockWrData,    // Lock bits to program (boot 3:2, app 1:0)
    input  wire logic        lpmStrobe,     // Load-program instruction pulse
    input  wire logic        eepromWriteBusy, // EEPROM write in progress
    input  wire logic [7:0]  fuseLowIn,     // Low fuse byte
    input  wire logic [2:0]  fuseHighIn,    // Boot size and reset vector fuses
    input  wire logic [1:0]  lockInit,      // Initial fused lock bits LB
    input  wire logic [15:0] flashRdWord,   // Flash word at flashRdAddr
    output logic [12:0]      flashRdAddr,   // Flash read word address
    output logic [7:0]       lpmData,       // Load result, valid cycle after strobe
    output logic             flashEraseGo,  // Page erase pulse
    output logic             flashWriteGo,  // Page write pulse
    output logic [6:0]       flashPage,     // Page for erase or write
    output logic [15:0]      bufWord[64],   // Temporary page buffer
    output logic [1:0]       appLock,       // Application lock bits
    output logic [1:0]       bootLock,      // Boot section lock bits
    output logic [12:0]      bootStart      // First word of boot section
);
    logic [1:0]  eeSync_q;
    logic        eeBusy;
    logic [2:0]  armCnt_q;
    logic        inBoot;
    logic        spmOk;
    logic [5:0]  bootPages;
    logic [1:0]  appLock_q;
    logic [1:0]  bootLock_q;
    logic [7:0]  lpmData_q;
    logic        eraseGo_q;
    logic        writeGo_q;
    logic [6:0]  page_q;
    logic [15:0] buf_q[64];

    // EEPROM busy comes from another block; synchronise it
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            eeSync_q <= 2'h0;
        end else begin
            eeSync_q <= {eeSync_q[0], eepromWriteBusy};
        end
    end
    assign eeBusy = eeSync_q[1];

    // Boot size decode from the fuse field
    always_comb begin
        case (fuseHighIn[2:1])
            2'h3:    bootPages = 6'h02;
            2'h2:    bootPages = 6'h04;
            2'h1:    bootPages = 6'h08;
            default: bootPages = 6'h10;
        endcase
    end
    assign bootStart = 13'(`PAGE_COUNT * `PAGE_WORDS) - 13'({bootPages, 6'h00});
    assign inBoot = fetchAddr >= bootStart;
    assign spmOk = spmStrobe && inBoot && !eeBusy;

    // Window during which a load returns fuse or lock bits
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            armCnt_q <= 3'h0;
        end else if (lockSetArm && !eeBusy) begin
            armCnt_q <= `READ_WINDOW;
        end else if (armCnt_q != 3'h0) begin
            armCnt_q <= armCnt_q - 3'h1;
        end
    end

    assign flashRdAddr = zPointer[13:1];

    // Fuse or lock readback while the window is open and EEPROM is not busy, plain byte read otherwise
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            lpmData_q <= 8'h00;
        end else if (lpmStrobe) begin
            if (armCnt_q != 3'h0 && !eeBusy) begin
                if (zPointer == `FUSE_LOW_ADDR) begin
                    lpmData_q <= {fuseLowIn[7:5], `UNUSED_FILL, fuseLowIn[3:0]};
                end else if (zPointer == `FUSE_HIGH_ADDR) begin
                    lpmData_q <= {{5{`UNUSED_FILL}}, fuseHighIn};
                end else begin
                    lpmData_q <= {2'h3, bootLock_q, appLock_q, lockInit};
                end
            end else begin
                lpmData_q <= zPointer[0] ? flashRdWord[15:8] : flashRdWord[7:0];
            end
        end
    end
    assign lpmData = lpmData_q;

    // Lock bits: only programming (clearing) is possible from software
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            appLock_q  <= 2'h3;
            bootLock_q <= 2'h3;
        end else if (spmOk && spmCmd == 3'(CMD_LOCK)) begin
            appLock_q  <= appLock_q & lockWrData[1:0];
            bootLock_q <= bootLock_q & lockWrData[3:2];
        end
    end
    assign appLock  = appLock_q;
    assign bootLock = bootLock_q;

    // Erase and write pulses carry the page chosen by the pointer
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            eraseGo_q <= 1'b0;
            writeGo_q <= 1'b0;
            page_q    <= 7'h00;
        end else begin
            eraseGo_q <= spmOk && spmCmd == 3'(CMD_ERASE) && !zPointer[0];
            writeGo_q <= spmOk && spmCmd == 3'(CMD_WRITE) && zPointer[6:0] == 7'h00;
            if (spmOk && (spmCmd == 3'(CMD_ERASE) || spmCmd == 3'(CMD_WRITE))) begin
                page_q <= zPointer[`PAGE_MSB:`PAGE_LSB];
            end
        end
    end
    assign flashEraseGo = eraseGo_q;
    assign flashWriteGo = writeGo_q;
    assign flashPage    = page_q;

    // Temporary page buffer, one word per entry
    genvar w;
    generate
        for (w = 0; w < 64; w++) begin : g_buf
            always_ff @(posedge sys_clk) begin
                if (!reset_n) begin
                    buf_q[w] <= 16'hFFFF;
                end else if (spmOk && spmCmd == 3'(CMD_FILL) && !zPointer[0]
                             && zPointer[`WORD_MSB:`WORD_LSB] == 6'(w)) begin
                    buf_q[w] <= spmData;
                end
            end
            assign bufWord[w] = buf_q[w];
        end
    endgenerate

    a_app_blocked: assert property (@(posedge sys_clk) disable iff (!reset_n)
        spmStrobe && fetchAddr < bootStart |=> !flashEraseGo && !flashWriteGo)
        else $error("programming from application section");
    a_ee_blocks: assert property (@(posedge sys_clk) disable iff (!reset_n)
        eeSync_q[1] && spmStrobe |=> !flashEraseGo && !flashWriteGo)
        else $error("programming during EEPROM write");
    a_boot_size: assert property (@(posedge sys_clk) disable iff (!reset_n)
        fuseHighIn[2:1] == 2'h0 |-> bootStart == 13'h1C00)
        else $error("boot size wrong");
    a_fuse_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
        lpmStrobe && armCnt_q != 3'h0 && !eeSync_q[1] && zPointer == 16'h0000
        |=> lpmData == {$past(fuseLowIn[7:5]), 1'b1, $past(fuseLowIn[3:0])})
        else $error("low fuse read wrong");
    a_fuse_high: assert property (@(posedge sys_clk) disable iff (!reset_n)
        lpmStrobe && armCnt_q != 3'h0 && !eeSync_q[1] && zPointer == 16'h0003
        |=> lpmData[2:0] == $past(fuseHighIn))
        else $error("high fuse read wrong");
    a_arm_window: assert property (@(posedge sys_clk) disable iff (!reset_n)
        lockSetArm && !eeSync_q[1] |=> armCnt_q == 3'h5)
        else $error("read window not opened");
    a_byte_sel: assert property (@(posedge sys_clk) disable iff (!reset_n)
        lpmStrobe && armCnt_q == 3'h0 && zPointer[0]
        |=> lpmData == $past(flashRdWord[15:8]))
        else $error("byte select wrong");
    a_lock_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ##1 (appLock & ~$past(appLock)) == 2'h0)
        else $error("lock bit unprogrammed");
    a_page_addr: assert property (@(posedge sys_clk) disable iff (!reset_n)
        spmOk && spmCmd == 3'(CMD_ERASE) |=> flashPage == $past(zPointer[13:7]))
        else $error("page address wrong");

    // Further guards on pointer use, pulses, locks and the read window
    a_write_page: assert property (@(posedge sys_clk) disable iff (!reset_n)
        spmOk && spmCmd == 3'(CMD_WRITE)
        |=> flashPage == $past(zPointer[13:7]))
        else $error("write page address wrong");
    a_write_word0: assert property (@(posedge sys_clk) disable iff (!reset_n)
        spmStrobe && zPointer[6:0] != 7'h00
        |=> !flashWriteGo)
        else $error("page write with nonzero word select");
    a_erase_pulse: assert property (@(posedge sys_clk) disable iff (!reset_n)
        flashEraseGo
        |=> !flashEraseGo)
        else $error("erase pulse too long");
    a_lock_no_z: assert property (@(posedge sys_clk) disable iff (!reset_n)
        spmOk && spmCmd == 3'(CMD_LOCK)
        |=> bootLock == ($past(bootLock) & $past(lockWrData[3:2])))
        else $error("boot lock update wrong");
    a_byte_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
        lpmStrobe && armCnt_q == 3'h0 && !zPointer[0]
        |=> lpmData == $past(flashRdWord[7:0]))
        else $error("low byte select wrong");
    a_lock_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
        lpmStrobe && armCnt_q != 3'h0 && !eeSync_q[1] && zPointer == 16'h0001
        |=> lpmData == {2'h3, $past(bootLock), $past(appLock), $past(lockInit)})
        else $error("lock readback wrong");
    a_ee_no_arm: assert property (@(posedge sys_clk) disable iff (!reset_n)
        eeSync_q[1] && armCnt_q == 3'h0
        |=> armCnt_q == 3'h0)
        else $error("read window opened during EEPROM write");
    a_app_no_lock: assert property (@(posedge sys_clk) disable iff (!reset_n)
        spmStrobe && fetchAddr < bootStart
        |=> appLock == $past(appLock) && bootLock == $past(bootLock))
        else $error("lock changed from application section");
    a_window_count: assert property (@(posedge sys_clk) disable iff (!reset_n)
        armCnt_q != 3'h0 && !(lockSetArm && !eeSync_q[1])
        |=> armCnt_q == $past(armCnt_q) - 3'h1)
        else $error("read window count wrong");
    a_fill_word: assert property (@(posedge sys_clk) disable iff (!reset_n)
        spmOk && spmCmd == 3'(CMD_FILL) && zPointer[6:0] == 7'h00
        |=> bufWord[0] == $past(spmData))
        else $error("buffer fill wrong");
endmodule
`default_nettype wire

// [flash_array_model.sv]
// Flash array model answering word reads and counting page operations
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
    input  wire logic        sys_clk,      // System clock
    input  wire logic [12:0] flashRdAddr,  // Word address
    input  wire logic        flashEraseGo, // Page erase pulse
    input  wire logic        flashWriteGo, // Page write pulse
    output logic      [15:0] flashRdWord   // Word at the address
);
    int pageOps = 0;
    // Address-derived pattern so every byte read is predictable
    assign flashRdWord = {flashRdAddr[7:0], 3'h5, flashRdAddr[12:8]};
    always @(posedge sys_clk) if (flashEraseGo || flashWriteGo) pageOps++;
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the boot self-programming sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import boot_prog_pkg::*;
    logic        sys_clk = 0, reset_n = 0, spmStrobe = 0, lockSetArm = 0;
    logic        lpmStrobe = 0, eepromWriteBusy = 0, flashEraseGo, flashWriteGo;
    logic [12:0] fetchAddr = 0, flashRdAddr, bootStart;
    logic [2:0]  spmCmd = 0, fuseHighIn = 3'h7;
    logic [15:0] zPointer = 0, spmData = 0, flashRdWord, z;
    logic [3:0]  lockWrData = 4'hF;
    logic [7:0]  fuseLowIn = 8'hA5, lpmData;
    logic [6:0]  flashPage;
    logic [1:0]  appLock, bootLock, lockInit = 2'h3;
    logic [15:0] bufWord[64];
    int          num_errors = 0, compares = 0;
    always #25 sys_clk = ~sys_clk;
    boot_self_programming dut (.sys_clk, .reset_n, .fetchAddr, .spmStrobe, .spmCmd,
        .zPointer, .spmData, .lockSetArm, .lockWrData, .lpmStrobe, .eepromWriteBusy,
        .fuseLowIn, .fuseHighIn, .lockInit, .flashRdWord, .flashRdAddr, .lpmData,
        .flashEraseGo, .flashWriteGo, .flashPage, .bufWord, .appLock, .bootLock, .bootStart);
    flash_array_model flash (.sys_clk, .flashRdAddr, .flashEraseGo, .flashWriteGo,
        .flashRdWord);
    function automatic logic [7:0] fb(input logic [15:0] zz);
        logic [15:0] w;
        w = {zz[8:1], 3'h5, zz[13:9]};
        return zz[0] ? w[15:8] : w[7:0];
    endfunction
    task chk(input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task store_program_instr(input logic [2:0] c, input logic [15:0] zz, input logic [12:0] fa);
        @(posedge sys_clk);
        spmStrobe <= 1'h1;
        spmCmd <= c;
        zPointer <= zz;
        spmData <= ~zz;
        fetchAddr <= fa;
        @(posedge sys_clk);
        spmStrobe <= 1'h0;
        #1;
    endtask
    task load_program_instr(input logic a, input logic [15:0] zz, input logic [7:0] e);
        @(posedge sys_clk);
        lockSetArm <= a;
        @(posedge sys_clk);
        lockSetArm <= 1'h0;
        lpmStrobe <= 1'h1;
        zPointer <= zz;
        @(posedge sys_clk);
        lpmStrobe <= 1'h0;
        #1 chk(lpmData, e);
        repeat (6) @(posedge sys_clk);
    endtask
    task report_and_stop;
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        void'($urandom(15));
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'h1;
        #1 chk({bootLock, appLock}, 16'h000F);
        for (int i = 0; i < 8; i++) begin
            z = 16'($urandom);
            load_program_instr(1'h0, z, fb(z));
        end
        $display("byte load test done");
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            fuseHighIn <= {i[1:0], i[0]};
            fuseLowIn <= 8'($urandom);
            z = 16'($urandom) & 16'hFF80;
            #1 load_program_instr(1'h1, 16'h0000, {fuseLowIn[7:5], 1'h1, fuseLowIn[3:0]});
            load_program_instr(1'h1, 16'h0003, {5'h1F, fuseHighIn});
            chk(bootStart, 16'h2000 - (16'h0080 << (2'h3 - fuseHighIn[2:1])));
            store_program_instr(CMD_ERASE, z, bootStart - 13'h1);
            chk(flashEraseGo, 16'h0000);
            store_program_instr(CMD_ERASE, z, bootStart);
            chk({flashEraseGo, flashPage}, {1'h1, z[13:7]});
            store_program_instr(CMD_WRITE, z, 13'h1FFF);
            chk({flashWriteGo, flashPage}, {1'h1, z[13:7]});
            z = 16'($urandom) & 16'h007E;
            store_program_instr(CMD_FILL, z, 13'h1FFF);
            chk(bufWord[z[6:1]], ~z);
        end
        $display("boot section test done");
        @(posedge sys_clk);
        eepromWriteBusy <= 1'h1;
        repeat (3) @(posedge sys_clk);
        store_program_instr(CMD_ERASE, 16'h0000, 13'h1FFF);
        chk(flashEraseGo, 16'h0000);
        load_program_instr(1'h1, 16'h0000, fb(16'h0000));
        eepromWriteBusy <= 1'h0;
        repeat (3) @(posedge sys_clk);
        $display("eeprom busy test done");
        lockWrData <= 4'($urandom);
        store_program_instr(CMD_LOCK, 16'($urandom), 13'h1FFF);
        chk({bootLock, appLock}, lockWrData);
        load_program_instr(1'h1, 16'h0001, {2'h3, lockWrData, 2'h3});
        $display("lock test done");
        report_and_stop;
    end
endmodule
`default_nettype wire
